// ---- design/asc_control.sv ----
// Sequencing control around the successive-approximation converter core
//
// Function
// R1: Enable bit 0 keeps converter active or idle
// R2: Run-in-standby bit 7 keeps converter in standby
// R3: Full resolution stores ten-bit value
// R4: Eight-bit resolution drops two lowest bits
// R5: Continuous mode restarts after each conversion
// R6: Continuous mode sets ready flag per conversion
// R7: Accumulation code selects 1 to 64 samples
// R8: Accumulated samples summed within one conversion
// R9: Capacitor select bit drives analog core
// R10: Reference field picks internal or supply
// R11: Converter clock is peripheral clock over 2^(n+1)
// R12: Startup delay after enable or internal reference
// R13: Startup delay also after deep-sleep wake
// R14: Dither increments inter-sample delay per sample
// R15: Dithered delay wraps from 15 to 0
// R16: Inter-sample gap equals delay field in clocks
// R17: Sampling switch open during the gap
// R18: Window mode selects compare condition
// R19: Start bit reads one while converting
// R20: Ready flag set on result, cleared by software
// R21: Sample length adds clocks beyond two
// R22: Sixteen-bit result accumulator
// R23: Unassigned bits read zero, writes ignored
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "asc_params.svh"

module asc_control (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire asc_pkg::asc_bus_req_type bus_i,
   output logic [7:0] rdata_o,
   input wire logic [9:0] core_data_i,
   input wire logic standby_i,
   input wire logic wake_i,
   input wire logic start_event_i,
   output asc_pkg::asc_core_ctl_type core_o,
   output logic ready_flag_o,
   output logic window_flag_o
);
   import asc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   function automatic logic [8:0] init_ticks(input logic [2:0] code);
      logic [8:0] t;
      t = 9'h000;
      case (code)
         3'h1: t = 9'h010;
         3'h2: t = 9'h020;
         3'h3: t = 9'h040;
         3'h4: t = 9'h080;
         3'h5: t = 9'h100;
         default: t = 9'h000;
      endcase
      return t;
   endfunction : init_ticks

   function automatic logic [6:0] sample_count(input logic [2:0] code);
      logic [6:0] n;
      n = 7'h01;
      if (code != 3'h7) begin
         n = 7'h01 << code;
      end
      return n;
   endfunction : sample_count

   function automatic logic window_match(input logic [2:0] mode, input logic [15:0] r,
                                         input logic [15:0] lo, input logic [15:0] hi);
      logic m;
      m = 1'b0;
      case (mode)
         ASC_WIN_BELOW: m = (r < lo);
         ASC_WIN_ABOVE: m = (r > hi);
         ASC_WIN_INSIDE: m = (r > lo) && (r < hi);
         ASC_WIN_OUTSIDE: m = (r < lo) || (r > hi);
         default: m = 1'b0;
      endcase
      return m;
   endfunction : window_match

   ////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] ctrl_main_q;
   logic [7:0] accum_q;
   logic [7:0] ref_clock_q;
   logic [7:0] delay_q;
   logic [7:0] window_q;
   logic [7:0] sample_len_q;
   logic [7:0] event_ctrl_q;
   logic [15:0] low_thr_q;
   logic [15:0] high_thr_q;
   logic [15:0] result_q;
   logic busy_q;
   logic ready_q;
   logic window_hit_q;
   logic need_init_q;
   logic event_q;
   logic [7:0] div_q;
   logic [7:0] rdata_q;
   asc_core_ctl_type core_q;
   asc_state_type state_q;
   logic [8:0] cnt_q;
   logic [6:0] idx_q;
   logic [15:0] acc_q;

   logic wr_main, wr_ref, wr_delay, wr_cmd, wr_flags;
   logic rd_result;
   logic active;
   logic tick;
   logic [7:0] div_mask;
   logic start_req;
   logic sample_done;
   logic conv_done;
   logic [15:0] sample_val;
   logic [15:0] acc_d;
   logic [8:0] sample_ticks;
   logic [8:0] gap_ticks;
   logic [6:0] n_samples;

   assign wr_main = bus_i.wr && (bus_i.addr == `ASC_OFF_CONTROL_MAIN);
   assign wr_ref = bus_i.wr && (bus_i.addr == `ASC_OFF_REF_CLOCK);
   assign wr_delay = bus_i.wr && (bus_i.addr == `ASC_OFF_DELAY);
   assign wr_cmd = bus_i.wr && (bus_i.addr == `ASC_OFF_COMMAND);
   assign wr_flags = bus_i.wr && (bus_i.addr == `ASC_OFF_FLAGS);
   assign rd_result = bus_i.rd && ((bus_i.addr == `ASC_OFF_RESULT_LO) || (bus_i.addr == `ASC_OFF_RESULT_HI));

   // Converter runs only when enabled and not stopped by standby
   assign active = ctrl_main_q[`ASC_BIT_ENABLE] &&
                   !(standby_i && !ctrl_main_q[`ASC_BIT_RUN_STANDBY]); // see R1 see R2

   ////////////////////////////////////////////////////////////////////////
   // Plain control registers

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ctrl_main_q <= `ASC_RESET_VALUE;
         accum_q <= `ASC_RESET_VALUE;
         ref_clock_q <= `ASC_RESET_VALUE;
         window_q <= `ASC_RESET_VALUE;
         sample_len_q <= `ASC_RESET_VALUE;
         event_ctrl_q <= `ASC_RESET_VALUE;
         low_thr_q <= 16'h0000;
         high_thr_q <= 16'h0000;
      end else if (bus_i.wr) begin
         case (bus_i.addr)
            `ASC_OFF_CONTROL_MAIN: ctrl_main_q <= bus_i.wdata & `ASC_MASK_CONTROL_MAIN; // see R23
            `ASC_OFF_ACCUMULATION: accum_q <= bus_i.wdata & `ASC_MASK_ACCUMULATION;
            `ASC_OFF_REF_CLOCK: ref_clock_q <= bus_i.wdata & `ASC_MASK_REF_CLOCK;
            `ASC_OFF_WINDOW: window_q <= bus_i.wdata & `ASC_MASK_WINDOW;
            `ASC_OFF_SAMPLE_LEN: sample_len_q <= bus_i.wdata & `ASC_MASK_SAMPLE_LEN;
            `ASC_OFF_EVENT_CTRL: event_ctrl_q <= {7'h00, bus_i.wdata[0]};
            `ASC_OFF_LOW_THR_LO: low_thr_q[7:0] <= bus_i.wdata;
            `ASC_OFF_LOW_THR_HI: low_thr_q[15:8] <= bus_i.wdata;
            `ASC_OFF_HIGH_THR_LO: high_thr_q[7:0] <= bus_i.wdata;
            `ASC_OFF_HIGH_THR_HI: high_thr_q[15:8] <= bus_i.wdata;
            default: ;
         endcase
      end
   end

   // Delay register, software write beats the dither step
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         delay_q <= `ASC_RESET_VALUE;
      end else if (wr_delay) begin
         delay_q <= bus_i.wdata & `ASC_MASK_DELAY;
      end else if (sample_done && delay_q[`ASC_BIT_DITHER]) begin
         delay_q[3:0] <= delay_q[3:0] + 4'h1; // see R14 see R15
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter clock divider

   assign div_mask = 8'((9'h002 << ref_clock_q[2:0]) - 9'h001);
   assign tick = ((div_q & div_mask) == div_mask); // see R11

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         div_q <= 8'h00;
      end else if (!active) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Start requests and startup delay

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         event_q <= 1'b0;
      end else begin
         event_q <= start_event_i;
      end
   end

   assign start_req = (wr_cmd && bus_i.wdata[0]) ||
                      (event_ctrl_q[0] && start_event_i && !event_q);

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         need_init_q <= 1'b0;
      end else if ((wr_main && bus_i.wdata[`ASC_BIT_ENABLE] && !ctrl_main_q[`ASC_BIT_ENABLE]) ||
                   (wr_ref && bus_i.wdata[5:4] == `ASC_REF_INTERNAL &&
                    ref_clock_q[5:4] != `ASC_REF_INTERNAL)) begin
         need_init_q <= 1'b1; // see R12
      end else if (wake_i) begin
         need_init_q <= 1'b1; // see R13
      end else if (state_q == ASC_IDLE && start_req && active) begin
         need_init_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sample sequencing

   assign n_samples = sample_count(accum_q[2:0]); // see R7
   assign sample_ticks = {3'h0, `ASC_BASE_SAMPLE_TICKS + {1'b0, sample_len_q[4:0]}}; // see R21
   assign gap_ticks = {5'h00, delay_q[3:0]}; // see R16
   assign sample_val = ctrl_main_q[`ASC_BIT_RESOLUTION] ? {8'h00, core_data_i[9:2]} // see R4
                                                        : {6'h00, core_data_i}; // see R3
   assign acc_d = acc_q + sample_val; // see R22
   assign sample_done = (state_q == ASC_CONVERT) && tick && (cnt_q == `ASC_CONVERT_TICKS - 9'h001);
   assign conv_done = sample_done && (idx_q == n_samples - 7'h01); // see R8

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i || !active) begin
         state_q <= ASC_IDLE; // see R1
         cnt_q <= 9'h000;
      end else begin
         case (state_q)
            ASC_IDLE: begin
               cnt_q <= 9'h000;
               if (start_req) begin
                  state_q <= (need_init_q && init_ticks(delay_q[7:5]) != 9'h000) ? ASC_INIT : ASC_SAMPLE;
               end
            end
            ASC_INIT: begin
               if (tick) begin
                  if (cnt_q == init_ticks(delay_q[7:5]) - 9'h001) begin
                     state_q <= ASC_SAMPLE; // see R12
                     cnt_q <= 9'h000;
                  end else begin
                     cnt_q <= cnt_q + 9'h001;
                  end
               end
            end
            ASC_SAMPLE: begin
               if (tick) begin
                  if (cnt_q == sample_ticks - 9'h001) begin
                     state_q <= ASC_CONVERT; // see R21
                     cnt_q <= 9'h000;
                  end else begin
                     cnt_q <= cnt_q + 9'h001;
                  end
               end
            end
            ASC_CONVERT: begin
               if (tick) begin
                  if (sample_done) begin
                     cnt_q <= 9'h000;
                     if (conv_done && !ctrl_main_q[`ASC_BIT_CONTINUOUS]) begin
                        state_q <= ASC_IDLE;
                     end else if ((delay_q[3:0] + {3'h0, delay_q[`ASC_BIT_DITHER]}) != 4'h0) begin // see R15
                        state_q <= ASC_GAP; // see R5 see R16
                     end else begin
                        state_q <= ASC_SAMPLE; // see R5
                     end
                  end else begin
                     cnt_q <= cnt_q + 9'h001;
                  end
               end
            end
            ASC_GAP: begin
               if (tick) begin
                  if (cnt_q + 9'h001 >= gap_ticks) begin
                     state_q <= ASC_SAMPLE; // see R16
                     cnt_q <= 9'h000;
                  end else begin
                     cnt_q <= cnt_q + 9'h001;
                  end
               end
            end
            default: begin
               state_q <= ASC_IDLE;
               cnt_q <= 9'h000;
            end
         endcase
      end
   end

   // Accumulator and sample index
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i || !active || state_q == ASC_IDLE) begin
         acc_q <= 16'h0000;
         idx_q <= 7'h00;
      end else if (conv_done) begin
         acc_q <= 16'h0000;
         idx_q <= 7'h00;
      end else if (sample_done) begin
         acc_q <= acc_d; // see R8
         idx_q <= idx_q + 7'h01;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         result_q <= 16'h0000;
      end else if (conv_done) begin
         result_q <= acc_d; // see R3 see R4 see R22
      end
   end

   // Start bit stays high while a conversion runs
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i || !active) begin
         busy_q <= 1'b0;
      end else if (state_q == ASC_IDLE) begin
         busy_q <= start_req; // see R19
      end else if (conv_done && !ctrl_main_q[`ASC_BIT_CONTINUOUS]) begin
         busy_q <= 1'b0; // see R19
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags, setting wins over clearing

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ready_q <= 1'b0;
      end else if (conv_done) begin
         ready_q <= 1'b1; // see R6 see R20
      end else if ((wr_flags && bus_i.wdata[`ASC_BIT_READY_FLAG]) || rd_result) begin
         ready_q <= 1'b0; // see R20
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         window_hit_q <= 1'b0;
      end else if (conv_done && window_match(window_q[2:0], acc_d, low_thr_q, high_thr_q)) begin
         window_hit_q <= 1'b1; // see R18
      end else if ((wr_flags && bus_i.wdata[`ASC_BIT_WINDOW_FLAG]) || rd_result) begin
         window_hit_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port, data valid only in the cycle after the strobe

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i || !bus_i.rd) begin
         rdata_q <= 8'h00;
      end else begin
         case (bus_i.addr)
            `ASC_OFF_CONTROL_MAIN: rdata_q <= ctrl_main_q;
            `ASC_OFF_ACCUMULATION: rdata_q <= accum_q;
            `ASC_OFF_REF_CLOCK: rdata_q <= ref_clock_q;
            `ASC_OFF_DELAY: rdata_q <= delay_q;
            `ASC_OFF_WINDOW: rdata_q <= window_q;
            `ASC_OFF_SAMPLE_LEN: rdata_q <= sample_len_q;
            `ASC_OFF_COMMAND: rdata_q <= {7'h00, busy_q}; // see R19
            `ASC_OFF_EVENT_CTRL: rdata_q <= event_ctrl_q;
            `ASC_OFF_FLAGS: rdata_q <= {6'h00, window_hit_q, ready_q};
            `ASC_OFF_RESULT_LO: rdata_q <= result_q[7:0];
            `ASC_OFF_RESULT_HI: rdata_q <= result_q[15:8];
            `ASC_OFF_LOW_THR_LO: rdata_q <= low_thr_q[7:0];
            `ASC_OFF_LOW_THR_HI: rdata_q <= low_thr_q[15:8];
            `ASC_OFF_HIGH_THR_LO: rdata_q <= high_thr_q[7:0];
            `ASC_OFF_HIGH_THR_HI: rdata_q <= high_thr_q[15:8];
            default: rdata_q <= 8'h00; // see R23
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Analog core controls

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         core_q <= '0;
      end else begin
         core_q.enable <= active; // see R1 see R2
         core_q.clk <= active && div_q[ref_clock_q[2:0]]; // see R11
         core_q.sample <= (state_q == ASC_SAMPLE); // see R17
         core_q.convert <= (state_q == ASC_CONVERT);
         core_q.cap_reduced <= ref_clock_q[`ASC_BIT_CAP_SELECT]; // see R9
         core_q.ref_select <= ref_clock_q[5:4]; // see R10
      end
   end

   assign core_o = core_q;
   assign rdata_o = rdata_q;
   assign ready_flag_o = ready_q;
   assign window_flag_o = window_hit_q;

endmodule : asc_control

// ---- design/asc_params.svh ----
// Offsets, field positions, reset values and timing counts of the converter control
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

`define ASC_ADDR_W 5
`define ASC_OFF_CONTROL_MAIN 5'h00
`define ASC_OFF_ACCUMULATION 5'h01
`define ASC_OFF_REF_CLOCK 5'h02
`define ASC_OFF_DELAY 5'h03
`define ASC_OFF_WINDOW 5'h04
`define ASC_OFF_SAMPLE_LEN 5'h05
`define ASC_OFF_COMMAND 5'h08
`define ASC_OFF_EVENT_CTRL 5'h09
`define ASC_OFF_FLAGS 5'h0b
`define ASC_OFF_RESULT_LO 5'h10
`define ASC_OFF_RESULT_HI 5'h11
`define ASC_OFF_LOW_THR_LO 5'h12
`define ASC_OFF_LOW_THR_HI 5'h13
`define ASC_OFF_HIGH_THR_LO 5'h14
`define ASC_OFF_HIGH_THR_HI 5'h15

`define ASC_MASK_CONTROL_MAIN 8'h87
`define ASC_MASK_ACCUMULATION 8'h07
`define ASC_MASK_REF_CLOCK 8'h77
`define ASC_MASK_DELAY 8'hff
`define ASC_MASK_WINDOW 8'h07
`define ASC_MASK_SAMPLE_LEN 8'h1f
`define ASC_RESET_VALUE 8'h00

`define ASC_BIT_ENABLE 0
`define ASC_BIT_CONTINUOUS 1
`define ASC_BIT_RESOLUTION 2
`define ASC_BIT_RUN_STANDBY 7
`define ASC_BIT_CAP_SELECT 6
`define ASC_BIT_DITHER 4
`define ASC_BIT_READY_FLAG 0
`define ASC_BIT_WINDOW_FLAG 1

`define ASC_REF_INTERNAL 2'h0
`define ASC_BASE_SAMPLE_TICKS 6'h02
`define ASC_CONVERT_TICKS 9'h00a
`define ASC_INIT_UNIT 9'h008

`endif

// ---- design/asc_pkg.sv ----
// Types shared by the converter control and its bench
package asc_pkg;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } asc_bus_req_type;

   typedef struct packed {
      logic enable;
      logic clk;
      logic sample;
      logic convert;
      logic cap_reduced;
      logic [1:0] ref_select;
   } asc_core_ctl_type;

   typedef enum logic [2:0] {
      ASC_IDLE = 3'b000,
      ASC_INIT = 3'b001,
      ASC_SAMPLE = 3'b010,
      ASC_CONVERT = 3'b011,
      ASC_GAP = 3'b100
   } asc_state_type;

   typedef enum logic [2:0] {
      ASC_WIN_NONE = 3'b000,
      ASC_WIN_BELOW = 3'b001,
      ASC_WIN_ABOVE = 3'b010,
      ASC_WIN_INSIDE = 3'b011,
      ASC_WIN_OUTSIDE = 3'b100
   } asc_window_type;

endpackage : asc_pkg

// ---- dv/asc_control_props.sv ----
// Port checker for the converter control
`timescale 1ns/1ps
module asc_control_props (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire asc_pkg::asc_bus_req_type bus_i,
   input wire logic [7:0] rdata_o,
   input wire asc_pkg::asc_core_ctl_type core_o,
   input wire logic ready_flag_o,
   input wire logic window_flag_o
);
   import asc_pkg::*;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);
   sequence cap_wr_s;
      bus_i.wr && bus_i.addr == 5'h02;
   endsequence
   sequence cap_hold_s;
      !(bus_i.wr && bus_i.addr == 5'h02) [*2];
   endsequence
   rdata_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
      else $error("read data outside reply");
   disabled_quiet_a: assert property (!core_o.enable [*2] |-> !core_o.sample && !core_o.convert)
      else $error("core active while disabled");
   phase_excl_a: assert property (!(core_o.sample && core_o.convert))
      else $error("sample switch closed while converting");
   ready_cause_a: assert property ($rose(ready_flag_o) |->
      $past(core_o.convert) || $past(core_o.convert, 2) || $past(core_o.convert, 3))
      else $error("ready flag without conversion");
   ready_clear_a: assert property (bus_i.wr && bus_i.addr == 5'h0b && bus_i.wdata[0] && !core_o.convert
      |=> !ready_flag_o)
      else $error("ready flag not cleared by write");
   ready_keep_a: assert property (bus_i.wr && bus_i.addr == 5'h0b && !bus_i.wdata[0] && ready_flag_o
      |=> ready_flag_o)
      else $error("ready flag cleared by zero write");
   read_clear_a: assert property (bus_i.rd && bus_i.addr[4:1] == 4'h8 && !core_o.convert
      |=> !ready_flag_o && !window_flag_o)
      else $error("flags not cleared by result read");
   window_pair_a: assert property ($rose(window_flag_o) |-> ready_flag_o)
      else $error("window flag without result");
   cap_follow_a: assert property (cap_wr_s ##1 cap_hold_s |=>
      core_o.cap_reduced == $past(bus_i.wdata[6], 3) && core_o.ref_select == $past(bus_i.wdata[5:4], 3))
      else $error("core selects do not follow register");
endmodule : asc_control_props

bind asc_control asc_control_props i_props (.ref_clk_i, .nrst_i, .bus_i, .rdata_o, .core_o, .ready_flag_o,
   .window_flag_o);

// ---- dv/asc_core_model.sv ----
// Behavioural model of the analog converter core
`timescale 1ns/1ps
module asc_core_model (
   input wire asc_pkg::asc_core_ctl_type core_i,
   input wire logic [9:0] level_i,
   output logic [9:0] data_o
);
   import asc_pkg::*;
   // Result only valid while converting, inverted otherwise
   assign data_o = core_i.convert ? level_i : ~level_i;
endmodule : asc_core_model

// ---- dv/asc_control_tb.sv ----
// Self-checking bench for the converter control
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
module asc_control_tb;
   import asc_pkg::*;
   typedef struct {string nm; logic [7:0] v;} asc_note_type;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   asc_bus_req_type bus_i = '0;
   logic standby_i = 1'b0;
   logic wake_i = 1'b0;
   logic start_event_i = 1'b0;
   logic [7:0] rdata_o;
   logic [9:0] core_data_i;
   logic [9:0] level = 10'h000;
   asc_core_ctl_type core_o;
   logic ready_flag_o;
   logic window_flag_o;
   logic rd_d = 1'b0;
   int errors = 0;
   int n_tests = 0;
   int p = 0;
   int n;
   int k;
   logic [31:0] seed = 32'hbc21;
   asc_note_type q[$];
   always #5 ref_clk_i = ~ref_clk_i;
   asc_control i_dut (.ref_clk_i, .nrst_i, .bus_i, .rdata_o, .core_data_i, .standby_i, .wake_i,
      .start_event_i, .core_o, .ready_flag_o, .window_flag_o);
   asc_core_model i_core (.core_i(core_o), .level_i(level), .data_o(core_data_i));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   ////////////////////////////////////////////////////////////////
   // Read monitor
   always @(posedge ref_clk_i) begin
      asc_note_type e;
      if (rd_d && q.size() > 0) begin
         e = q.pop_front();
         `CHK(e.nm, e.v, rdata_o)
      end
      rd_d = bus_i.rd;
   end
   ////////////////////////////////////////////////////////////////
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      bus_i.wr <= 1'b1;
      bus_i.addr <= a;
      bus_i.wdata <= d;
      @(posedge ref_clk_i);
      bus_i.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] v, input string nm);
      @(posedge ref_clk_i);
      bus_i.rd <= 1'b1;
      bus_i.addr <= a;
      q.push_back('{nm, v});
      @(posedge ref_clk_i);
      bus_i.rd <= 1'b0;
   endtask : rd
   // Start by write (0), event (1) or none (2), then wait for the result and time it unless none
   task automatic run(input int ticks, input int mode);
      if (mode == 1) begin
         @(posedge ref_clk_i);
         start_event_i <= 1'b1;
      end else if (mode == 0) wr(5'h08, 8'h01);
      n = 0;
      while (ready_flag_o !== 1'b1 && n < 70000) begin
         @(posedge ref_clk_i);
         n++;
      end
      start_event_i <= 1'b0;
      `CHK("ready", 1'b1, ready_flag_o)
      if (mode != 2) `CHK("conv_time", 1'b1, n >= ((ticks - 1) << (p + 1)) + 2 && n <= (ticks << (p + 1)) + 2)
   endtask : run
   task automatic res(input logic [15:0] v, input logic w);
      `CHK("window_flag", w, window_flag_o)
      rd(5'h0b, {6'h00, w, 1'b1}, "flags");
      rd(5'h10, v[7:0], "result_lo");
      rd(5'h11, v[15:8], "result_hi");
      rd(5'h0b, 8'h00, "flags_read_clr");
   endtask : res
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      errors++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] mask [5] = '{8'h87, 8'h07, 8'h77, 8'hff, 8'h07};
      logic [9:0] lv [3] = '{10'd150, 10'd50, 10'd250};
      logic w;
      repeat (12) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(5'(i), 8'h00, "reset_value");
         wr(5'(i), 8'hff);
         rd(5'(i), mask[i], "mask");
         wr(5'(i), 8'h00);
      end
      rd(5'h1f, 8'h00, "unmapped");
      $display("done registers");
      wr(5'h03, 8'h20);
      wr(5'h00, 8'h01);
      level <= 10'(rnd());
      run(28, 0);
      res({6'h00, level}, 1'b0);
      for (int c = 0; c < 8; c++) begin
         k = c == 7 ? 1 : 1 << c;
         wr(5'h00, {5'h00, 1'(c), 2'b01});
         wr(5'h01, 8'(c));
         level <= 10'(rnd());
         run(12 * k, 0);
         res(16'(k * (c[0] ? level >> 2 : level)), 1'b0);
      end
      $display("done accumulation");
      wr(5'h00, 8'h01);
      wr(5'h01, 8'h00);
      wr(5'h05, 8'h03);
      for (p = 0; p < 8; p++) begin
         wr(5'h02, 8'(p) | 8'h40);
         run(15, 0);
         k = 0;
         w = core_o.clk;
         repeat (4 << p) begin
            @(negedge ref_clk_i);
            k += int'(core_o.clk && !w);
            w = core_o.clk;
         end
         `CHK("core_clk_rises", 2, k)
         res({6'h00, level}, 1'b0);
      end
      p = 0;
      wr(5'h02, 8'h10);
      wr(5'h05, 8'h00);
      $display("done divider");
      wr(5'h01, 8'h01);
      wr(5'h03, 8'h05);
      run(29, 0);
      res(16'(2 * level), 1'b0);
      wr(5'h03, 8'h1f);
      run(24, 0);
      res(16'(2 * level), 1'b0);
      rd(5'h03, 8'h11, "dither_wrap");
      $display("done delays");
      wr(5'h01, 8'h00);
      wr(5'h03, 8'h00);
      wr(5'h12, 8'd100);
      wr(5'h14, 8'd200);
      for (int m = 0; m < 5; m++) begin
         wr(5'h04, 8'(m));
         for (int j = 0; j < 3; j++) begin
            level <= lv[j];
            w = (m == 1 && lv[j] < 100) || (m == 2 && lv[j] > 200) || (m == 3 && lv[j] > 100 && lv[j] < 200)
               || (m == 4 && (lv[j] < 100 || lv[j] > 200));
            run(12, 0);
            res({6'h00, lv[j]}, w);
         end
      end
      $display("done window");
      wr(5'h04, 8'h00);
      run(12, 0);
      wr(5'h0b, 8'h00);
      rd(5'h0b, 8'h01, "flag_keep");
      wr(5'h0b, 8'h01);
      rd(5'h0b, 8'h00, "flag_clear");
      wr(5'h00, 8'h03);
      run(12, 0);
      rd(5'h08, 8'h01, "busy_run");
      wr(5'h0b, 8'h01);
      run(12, 2);
      wr(5'h00, 8'h00);
      rd(5'h08, 8'h00, "busy_abort");
      `CHK("core_enable", 1'b0, core_o.enable)
      $display("done continuous");
      wr(5'h0b, 8'h03);
      standby_i <= 1'b1;
      wr(5'h00, 8'h01);
      wr(5'h08, 8'h01);
      repeat (40) @(posedge ref_clk_i);
      `CHK("standby_stop", 1'b0, ready_flag_o)
      wr(5'h00, 8'h81);
      run(12, 0);
      res({6'h00, level}, 1'b0);
      standby_i <= 1'b0;
      wr(5'h03, 8'h20);
      wr(5'h09, 8'h01);
      @(posedge ref_clk_i);
      wake_i <= 1'b1;
      @(posedge ref_clk_i);
      wake_i <= 1'b0;
      run(28, 1);
      res({6'h00, level}, 1'b0);
      $display("done standby and wake");
      final_report();
   end
endmodule : asc_control_tb
